// file: iscb_map.svh
`ifndef ISCB_MAP_SVH
`define ISCB_MAP_SVH
`define ISCB_IDX_IFSTAT 6'h01
`define ISCB_IDX_GCTRL 6'h02
`define ISCB_IDX_DETCTL 6'h03
`define ISCB_IDX_FLAGS 6'h04
`define ISCB_IDX_STEER 6'h05
`define ISCB_IDX_WINEN 6'h06
`define ISCB_IDX_PINMODE 6'h07
`define ISCB_IO_BASE 8
`define ISCB_IO_STRIDE 4
`define ISCB_MEM_BASE 16
`define ISCB_MEM_STRIDE 8
`define ISCB_REGS 64
`define ISCB_MEM_WINS 5
`define ISCB_IO_WINS 2
`define ISCB_GC_PD 0
`define ISCB_GC_EDGE 1
`define ISCB_GC_EXPL 2
`define ISCB_GC_RING 3
`define ISCB_DC_AUXEN 2
`define ISCB_IO_EN_LSB 5
`define ISCB_MW_W16 7
`define ISCB_MW_ATTR 6
`define ISCB_PM_ATA 2'h1
`define ISCB_PM_DMA 2'h2
`define ISCB_IRQ_MAP 40'hFECBA97543
`define ISCB_IRQ_CODES 4'hA
`define ISCB_PULSE_CYC 2'h3
`define ISCB_LOW64K 8'h00
`define ISCB_LED_IRQ 12
`define ISCB_DACK_IRQ 9
`define ISCB_DREQ_IRQ 10
`define ISCB_TC_IRQ 11
`endif

// file: iscb_pkg.sv
package iscb_pkg;
  typedef struct packed {
    logic [23:0] addr;
    logic memr_n;
    logic memw_n;
    logic iord_n;
    logic iowr_n;
    logic sbhe_n;
    logic aen;
  } iscb_host_type;
  typedef struct packed {
    logic active;
    logic io;
    logic [25:0] addr;
    logic ce1_n;
    logic ce2_n;
    logic reg_n;
    logic w16;
    logic [1:0] waits;
  } iscb_card_type;
endpackage : iscb_pkg

// file: iscb_bridge.sv
`timescale 1ns/100ps
`include "iscb_map.svh"
module iscb_bridge (
  input wire logic core_clk,
  input wire logic resetn,
  input iscb_pkg::iscb_host_type host,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [5:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic card_det_n,
  input wire logic card_ready,
  input wire logic card_ireq_n,
  input wire logic card_ri_n,
  input wire logic card_dreq,
  input wire logic volt_sense_aux_input,
  input wire logic [15:0] irq_in,
  output iscb_pkg::iscb_card_type card_q,
  output logic card_dack_q,
  output logic card_tc_q,
  output logic [15:0] irq_q,
  output logic [15:0] irq_oe_q,
  output logic event_pulse_out_n,
  output logic ring_resume_out_n
);
  logic [1:0] rst_sync_q;
  logic rst_q;
  logic [7:0] cfg_q [0:`ISCB_REGS-1];
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic det_q;
  logic rdy_q;
  logic aux_q;
  logic ireq_q;
  logic primed_q;
  logic [1:0] pcnt_q;
  logic [1:0] pcnt_d;
  iscb_pkg::iscb_card_type card_d;

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Configuration bytes
  wire [7:0] gctrl = cfg_q[`ISCB_IDX_GCTRL];
  wire [7:0] winen = cfg_q[`ISCB_IDX_WINEN];
  wire [7:0] steer = cfg_q[`ISCB_IDX_STEER];
  wire [1:0] pmode = cfg_q[`ISCB_IDX_PINMODE][1:0];
  wire pd = gctrl[`ISCB_GC_PD];
  wire edge_mode = gctrl[`ISCB_GC_EDGE];
  wire expl = gctrl[`ISCB_GC_EXPL];
  wire aux_en = cfg_q[`ISCB_IDX_DETCTL][`ISCB_DC_AUXEN];
  wire wr_flags = reg_wr && reg_idx == `ISCB_IDX_FLAGS;
  wire rd_flags = reg_rd && reg_idx == `ISCB_IDX_FLAGS;
  wire cfg_wr = reg_wr && reg_idx != `ISCB_IDX_FLAGS && reg_idx != `ISCB_IDX_IFSTAT;

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      for (int i = 0; i < `ISCB_REGS; i++) begin
        cfg_q[i] <= 8'h00;
      end
    end else if (cfg_wr) begin
      cfg_q[reg_idx] <= reg_wdata;
    end
  end

  // Status: bit7 inverted sense input, bit1 ready, bit0 card present
  wire [7:0] ifstat = {~volt_sense_aux_input, 5'h00, card_ready, ~card_det_n};
  wire [7:0] rd_mux = reg_idx == `ISCB_IDX_IFSTAT ? ifstat :
                      reg_idx == `ISCB_IDX_FLAGS ? flags_q : cfg_q[reg_idx];

  ////////////////////////////////////////////////////////////////////////
  // Window decode; power-down masks every host strobe
  wire mem_req = !pd && (!host.memr_n || !host.memw_n);
  wire io_req = !pd && !host.aen && (!host.iord_n || !host.iowr_n);
  wire above64k = host.addr[23:16] != `ISCB_LOW64K;
  logic [`ISCB_MEM_WINS-1:0] mem_hit;
  logic [`ISCB_IO_WINS-1:0] io_hit;

  for (genvar w = 0; w < `ISCB_MEM_WINS; w++) begin : g_mem
    localparam int B = `ISCB_MEM_BASE + w * `ISCB_MEM_STRIDE;
    wire [11:0] start = {cfg_q[B+1][3:0], cfg_q[B]};
    wire [11:0] stop = {cfg_q[B+3][3:0], cfg_q[B+2]};
    wire [11:0] page = host.addr[23:12];
    assign mem_hit[w] = winen[w] && mem_req && above64k &&
                        page >= start && page <= stop;
  end
  for (genvar w = 0; w < `ISCB_IO_WINS; w++) begin : g_io
    localparam int B = `ISCB_IO_BASE + w * `ISCB_IO_STRIDE;
    wire [15:0] start = {cfg_q[B+1], cfg_q[B]};
    wire [15:0] stop = {cfg_q[B+3], cfg_q[B+2]};
    assign io_hit[w] = winen[`ISCB_IO_EN_LSB + w] && io_req &&
                       host.addr[15:0] >= start && host.addr[15:0] <= stop;
  end

  // Lowest numbered hitting window wins
  always_comb begin
    int b;
    b = 0;
    card_d = '0;
    card_d.ce1_n = 1'b1;
    card_d.ce2_n = 1'b1;
    card_d.reg_n = 1'b1;
    for (int w = `ISCB_MEM_WINS - 1; w >= 0; w--) begin
      if (mem_hit[w]) begin
        b = `ISCB_MEM_BASE + w * `ISCB_MEM_STRIDE;
        card_d.active = 1'b1;
        card_d.io = 1'b0;
        card_d.addr = {2'b00, host.addr} + {cfg_q[b+5][5:0], cfg_q[b+4], 12'h000};
        card_d.w16 = cfg_q[b+1][`ISCB_MW_W16];
        card_d.waits = cfg_q[b+3][7:6];
        card_d.reg_n = !cfg_q[b+5][`ISCB_MW_ATTR];
      end
    end
    if (mem_hit == '0) begin
      for (int w = `ISCB_IO_WINS - 1; w >= 0; w--) begin
        if (io_hit[w]) begin
          card_d.active = 1'b1;
          card_d.io = 1'b1;
          card_d.addr = {10'h000, host.addr[15:0]};
          card_d.reg_n = 1'b0;
        end
      end
    end
    if (card_d.active) begin
      card_d.ce2_n = !(card_d.w16 && !host.sbhe_n);
      card_d.ce1_n = card_d.w16 && !host.sbhe_n && host.addr[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change flags and interrupt steering
  wire [7:0] ev_raw = {5'h00,
                       aux_en && (volt_sense_aux_input != aux_q),
                       card_ready != rdy_q,
                       card_det_n != det_q};
  // Edge registers hold reset constants until the first sample; that compare is no event
  wire [7:0] ev_set = primed_q ? ev_raw : 8'h00;
  wire [7:0] ev_clr = expl ? (wr_flags ? reg_wdata : 8'h00) :
                      (rd_flags ? 8'hFF : 8'h00);
  assign flags_d = (flags_q & ~ev_clr) | ev_set;
  wire pending = flags_q != 8'h00;
  wire chg_rise = !pending && ev_set != 8'h00;
  wire card_req = !card_ireq_n;
  wire card_rise = card_req && !ireq_q;
  wire trig = chg_rise || card_rise;
  assign pcnt_d = (trig && pcnt_q == 2'h0) ? `ISCB_PULSE_CYC :
                  (pcnt_q != 2'h0) ? pcnt_q - 2'h1 : 2'h0;

  wire [3:0] chg_sel = steer[3:0];
  wire [3:0] crd_sel = steer[7:4];
  wire chg_ok = chg_sel < `ISCB_IRQ_CODES;
  wire crd_ok = crd_sel < `ISCB_IRQ_CODES;
  wire [39:0] irq_map = `ISCB_IRQ_MAP;
  wire [3:0] chg_line = chg_ok ? irq_map[chg_sel*4 +: 4] : 4'h0;
  wire [3:0] crd_line = crd_ok ? irq_map[crd_sel*4 +: 4] : 4'h0;
  wire chg_sig = edge_mode ? chg_rise : pending;
  wire crd_sig = edge_mode ? card_rise : card_req;
  wire ata = pmode == `ISCB_PM_ATA;
  wire dma = pmode == `ISCB_PM_DMA;
  logic [15:0] irq_d;
  logic [15:0] oe_d;

  for (genvar i = 0; i < 16; i++) begin : g_irq
    wire to_chg = chg_ok && chg_line == i;
    wire to_crd = crd_ok && crd_line == i;
    if (i == `ISCB_LED_IRQ) begin : g_led
      assign irq_d[i] = ata ? card_q.active : (to_chg && chg_sig) || (to_crd && crd_sig);
      assign oe_d[i] = ata || to_chg || to_crd;
    end else if (i == `ISCB_DREQ_IRQ) begin : g_dreq
      assign irq_d[i] = dma ? card_dreq : (to_chg && chg_sig) || (to_crd && crd_sig);
      assign oe_d[i] = dma || to_chg || to_crd;
    end else if (i == `ISCB_DACK_IRQ || i == `ISCB_TC_IRQ) begin : g_in
      assign irq_d[i] = !dma && ((to_chg && chg_sig) || (to_crd && crd_sig));
      assign oe_d[i] = !dma && (to_chg || to_crd);
    end else begin : g_plain
      assign irq_d[i] = (to_chg && chg_sig) || (to_crd && crd_sig);
      assign oe_d[i] = to_chg || to_crd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      flags_q <= 8'h00;
      det_q <= 1'b1;
      rdy_q <= 1'b0;
      aux_q <= 1'b1;
      ireq_q <= 1'b0;
      primed_q <= 1'b0;
      pcnt_q <= 2'h0;
      event_pulse_out_n <= 1'b1;
      ring_resume_out_n <= 1'b1;
      irq_q <= 16'h0000;
      irq_oe_q <= 16'h0000;
      reg_rdata_q <= 8'h00;
      card_q <= '0;
      card_dack_q <= 1'b1;
      card_tc_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      det_q <= card_det_n;
      rdy_q <= card_ready;
      aux_q <= volt_sense_aux_input;
      ireq_q <= card_req;
      primed_q <= 1'b1;
      pcnt_q <= pcnt_d;
      event_pulse_out_n <= pcnt_d == 2'h0;
      ring_resume_out_n <= !(gctrl[`ISCB_GC_RING] && !card_ri_n);
      irq_q <= irq_d;
      irq_oe_q <= oe_d;
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      card_q <= card_d;
      card_dack_q <= dma ? irq_in[`ISCB_DACK_IRQ] : 1'b1;
      card_tc_q <= dma && irq_in[`ISCB_TC_IRQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_q);

  a_pulse_three_low: assert property (
    $fell(event_pulse_out_n) |-> !event_pulse_out_n [*3] ##1 event_pulse_out_n)
    else $error("event pulse not three cycles low");
  a_no_repeat_pulse: assert property (
    pending && !card_rise && pcnt_q == 2'h0 |=> event_pulse_out_n)
    else $error("pulse repeated while change pending");
  a_read_clears: assert property (
    rd_flags && !expl && ev_set == 8'h00 |=> flags_q == 8'h00)
    else $error("flag read did not clear");
  a_write_ack: assert property (
    wr_flags && expl && ev_set == 8'h00 |=> (flags_q & $past(reg_wdata)) == 8'h00)
    else $error("write-back ack did not clear");
  a_pd_idle: assert property (
    pd |=> !card_q.active)
    else $error("card cycle while powered down");
  a_dma_no_io: assert property (
    host.aen |=> !(card_q.active && card_q.io))
    else $error("io mapped during dma");
  a_low64k_miss: assert property (
    host.addr[23:16] == `ISCB_LOW64K && !(io_hit != '0) |=> !card_q.active)
    else $error("memory window hit below 64k");
  a_byte_enables: assert property (
    card_q.active && (!card_q.w16 || $past(host.sbhe_n)) |-> card_q.ce2_n && !card_q.ce1_n)
    else $error("card enable decode wrong");
endmodule : iscb_bridge

// file: iscb_slot_model.sv
`timescale 1ns/100ps
module iscb_slot_model (
  input wire logic core_clk,
  input iscb_pkg::iscb_card_type card_q,
  output logic card_det_n,
  output logic card_ready,
  output logic card_ireq_n,
  output logic card_ri_n,
  output logic card_dreq,
  output logic volt_sense_aux_input
);
  initial begin
    card_det_n = 1'b0;
    card_ready = 1'b1;
    card_ireq_n = 1'b1;
    card_ri_n = 1'b1;
    card_dreq = 1'b0;
    volt_sense_aux_input = 1'b0;
  end
  // Card removal or insertion seen on the detect contact
  task automatic flip_detect();
    @(posedge core_clk);
    card_det_n <= ~card_det_n;
  endtask : flip_detect
  // DMA request and ring indicate levels from the card
  task automatic drive_lines(input logic dreq, input logic ri_n);
    @(posedge core_clk);
    card_dreq <= dreq;
    card_ri_n <= ri_n;
  endtask : drive_lines
endmodule : iscb_slot_model

// file: tb.sv
`timescale 1ns/100ps
`include "iscb_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  iscb_pkg::iscb_host_type host = '{24'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [5:0] reg_idx = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rd_data;
  logic [15:0] irq_in = 16'hFFFF;
  logic [7:0] reg_rdata_q;
  iscb_pkg::iscb_card_type card_q;
  logic card_det_n, card_ready, card_ireq_n, card_ri_n, card_dreq, volt_sense_aux_input;
  logic card_dack_q, card_tc_q, event_pulse_out_n, ring_resume_out_n;
  logic [15:0] irq_q, irq_oe_q;
  int err_total = 0;
  int samples_checked = 0;
  int irq_map [10] = '{3, 4, 5, 7, 9, 10, 11, 12, 14, 15};
  iscb_bridge iscb_bridge_inst (.core_clk(core_clk), .resetn(resetn), .host(host),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .card_det_n(card_det_n), .card_ready(card_ready),
    .card_ireq_n(card_ireq_n), .card_ri_n(card_ri_n), .card_dreq(card_dreq),
    .volt_sense_aux_input(volt_sense_aux_input), .irq_in(irq_in), .card_q(card_q),
    .card_dack_q(card_dack_q), .card_tc_q(card_tc_q), .irq_q(irq_q), .irq_oe_q(irq_oe_q),
    .event_pulse_out_n(event_pulse_out_n), .ring_resume_out_n(ring_resume_out_n));
  iscb_slot_model iscb_slot_model_inst (.core_clk(core_clk), .card_q(card_q),
    .card_det_n(card_det_n), .card_ready(card_ready), .card_ireq_n(card_ireq_n),
    .card_ri_n(card_ri_n), .card_dreq(card_dreq),
    .volt_sense_aux_input(volt_sense_aux_input));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    @(posedge core_clk);
    reg_idx <= i;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] i);
    @(posedge core_clk);
    reg_idx <= i;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_data = reg_rdata_q;
  endtask : rd
  // Strobe order memr, memw, iord, iowr; card side checked two edges on
  task automatic bus(input logic [23:0] a, input logic [3:0] s, input logic be, input logic dma);
    @(posedge core_clk);
    host <= '{a, s[3], s[2], s[1], s[0], be, dma};
    repeat (2) @(posedge core_clk);
    #1;
  endtask : bus
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_mem();
    // Pages 10h..11h, offset -16 pages, 16-bit, two waits, common space
    wr(6'h10, 8'h10); wr(6'h11, 8'h80); wr(6'h12, 8'h11); wr(6'h13, 8'h80);
    wr(6'h14, 8'hF0); wr(6'h15, 8'h3F); wr(`ISCB_IDX_WINEN, 8'h01);
    bus(24'h010004, 4'h7, 1'b0, 1'b0);
    `CHK("mem_act", 1'b1, card_q.active)
    `CHK("mem_addr", 26'h0000004, card_q.addr)
    `CHK("mem_waits", 2'h2, card_q.waits)
    `CHK("mem_common", 1'b1, card_q.reg_n)
    bus(24'h011FFF, 4'h7, 1'b0, 1'b0);
    `CHK("mem_stop", 1'b1, card_q.active)
    bus(24'h012000, 4'h7, 1'b0, 1'b0);
    `CHK("mem_miss", 1'b0, card_q.active)
    for (int k = 0; k < 8; k++) begin
      wr(6'h11, {k[2], 7'h00});
      bus({23'h008002, k[0]}, 4'h7, k[1], 1'b0);
      `CHK("ce2_n", ~(k[2] & ~k[1]), card_q.ce2_n)
      `CHK("ce1_n", k[2] & ~k[1] & k[0], card_q.ce1_n)
    end
    wr(6'h15, 8'h7F);
    bus(24'h010004, 4'h7, 1'b0, 1'b0);
    `CHK("mem_attr", 1'b0, card_q.reg_n)
    wr(6'h10, 8'h00);
    bus(24'h00F000, 4'h7, 1'b0, 1'b0);
    `CHK("mem_low64k", 1'b0, card_q.active)
  endtask : t_mem
  task automatic t_io();
    wr(6'h08, 8'h00); wr(6'h09, 8'h03); wr(6'h0A, 8'h03); wr(6'h0B, 8'h03);
    wr(`ISCB_IDX_WINEN, 8'h20);
    bus(24'h000303, 4'hD, 1'b1, 1'b0);
    `CHK("io_act", 1'b1, card_q.active)
    `CHK("io_kind", 1'b1, card_q.io)
    bus(24'h000304, 4'hD, 1'b1, 1'b0);
    `CHK("io_miss", 1'b0, card_q.active)
    bus(24'h000300, 4'hD, 1'b1, 1'b1);
    `CHK("io_dma", 1'b0, card_q.active)
    wr(`ISCB_IDX_GCTRL, 8'h01);
    bus(24'h000300, 4'hD, 1'b1, 1'b0);
    `CHK("io_pd", 1'b0, card_q.active)
  endtask : t_io
  task automatic t_evt(input logic [3:0] c);
    int n;
    n = 0;
    wr(`ISCB_IDX_GCTRL, {7'h00, c < 4'h5});
    wr(`ISCB_IDX_STEER, {4'hF, c});
    iscb_slot_model_inst.flip_detect();
    while (event_pulse_out_n !== 1'b0 && n < 8) begin
      @(posedge core_clk);
      #1 n++;
    end
    n = 0;
    while (event_pulse_out_n === 1'b0 && n < 8) begin
      @(posedge core_clk);
      #1 n++;
    end
    `CHK("pulse_len", 3, n)
    `CHK("irq_line", 1'b1, irq_q[irq_map[c]] & irq_oe_q[irq_map[c]])
    n = 0;
    iscb_slot_model_inst.flip_detect();
    repeat (6) begin
      @(posedge core_clk);
      #1 n += (event_pulse_out_n === 1'b0);
    end
    `CHK("no_repeat", 0, n)
    rd(`ISCB_IDX_FLAGS);
    `CHK("flags", 8'h01, rd_data)
    rd(`ISCB_IDX_FLAGS);
    `CHK("flags_clr", 8'h00, rd_data)
    `CHK("irq_level", 1'b0, irq_q[irq_map[c]])
  endtask : t_evt
  task automatic t_pin();
    wr(`ISCB_IDX_PINMODE, 8'h02);
    wr(`ISCB_IDX_GCTRL, 8'h08);
    irq_in <= 16'hFDFF;
    iscb_slot_model_inst.drive_lines(1'b1, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("dack", 1'b0, card_dack_q)
    `CHK("tc", 1'b1, card_tc_q)
    `CHK("dreq", 1'b1, irq_q[10] & irq_oe_q[10])
    `CHK("dack_oe", 1'b0, irq_oe_q[9])
    `CHK("ring", 1'b0, ring_resume_out_n)
    wr(`ISCB_IDX_PINMODE, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("led_oe", 1'b1, irq_oe_q[12])
    `CHK("led", 1'b1, irq_q[12])
    iscb_slot_model_inst.drive_lines(1'b0, 1'b1);
    irq_in <= 16'hFFFF;
    wr(`ISCB_IDX_PINMODE, 8'h00);
  endtask : t_pin
  task automatic t_ack();
    wr(`ISCB_IDX_GCTRL, 8'h04);
    iscb_slot_model_inst.flip_detect();
    repeat (6) @(posedge core_clk);
    rd(`ISCB_IDX_FLAGS);
    rd(`ISCB_IDX_FLAGS);
    `CHK("expl_keep", 8'h01, rd_data)
    wr(`ISCB_IDX_FLAGS, 8'h01);
    rd(`ISCB_IDX_FLAGS);
    `CHK("expl_ack", 8'h00, rd_data)
    rd(`ISCB_IDX_IFSTAT);
    `CHK("sense_inv", ~volt_sense_aux_input, rd_data[7])
  endtask : t_ack
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_mem();
    t_io();
    for (int k = 0; k < 10; k++) begin
      t_evt(k[3:0]);
    end
    t_pin();
    t_ack();
    end_sim();
  end
endmodule : tb
